// ---- hdl/cks_key_mem.sv ----
// Purpose: Storage of the software key register words
// Assumes: One write and one read port
// Notes: Read data come out of a register
`include "cks_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module cks_key_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("cks_key_mem: bad size");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_next;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en) begin
      mem_next[wr_addr] = wr_data;
    end
    rd_next = mem_reg[rd_addr];
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_reg[i] <= rstn ? mem_next[i] : WIDTH'(`CKS_KEY_RESET);
    end
    rd_data <= rstn ? rd_next : '0;
  end

endmodule : cks_key_mem

`default_nettype wire

// ---- hdl/cks_key_source.sv ----
// Purpose: Key-source selection and OTP page protection
// Assumes: Page 0 word offered on cfg_page_word with cfg_page_valid after reset
// Notes: Registers on a plain strobe port, read data one cycle later
`include "cks_regs.svh"
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Key type bits 21-20 limit pages 1-2 keys to one algorithm.
// - Session-key-only bit 19 restricts stored key one to key wrapping.
// - Lock bit 10 takes source from locked field, ignoring software select.
// - Locked field priority-encoded from top bit: 1111, 0111, 0110..0001, 0000.
// - Lock clear: locked field ignored, software select field used.
// - Write-lock bits 9-1 block programming of pages 0 through 8.
// - Software key disabled with source 0000 sets failure and refuses starts.
// - Software key enabled with source 0000 makes software key active.
module cks_key_source #(
  parameter int PAGES = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // OTP page 0 load
  input wire logic cfg_page_valid,
  input wire logic [31:0] cfg_page_word,
  // OTP programming request
  input wire logic prog_req,
  input wire logic [3:0] prog_page,
  output logic prog_grant,
  output logic prog_refused,
  // Cipher engine side
  output logic op_start,
  output logic [1:0] op_kind,
  output logic [3:0] active_source,
  output logic use_software_key,
  output logic [1:0] stored_alg,
  output logic [127:0] software_key,
  output logic key_failure_flag
);

  initial begin
    if (PAGES != 9) $error("cks_key_source: PAGES must be 9");
  end

  // ==========================================================
  // Configuration capture
  typedef enum logic [0:0] {CKS_WAIT_CFG, CKS_HELD} cks_state_t;
  cks_state_t state_reg, state_next;
  cks_pkg::cks_cfg_t cfg_reg, cfg_next;

  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    case (state_reg)
      CKS_WAIT_CFG: begin
        if (cfg_page_valid) begin
          cfg_next = cks_pkg::cks_cfg_t'(cfg_page_word[21:0]);
          state_next = CKS_HELD;
        end
      end
      CKS_HELD: state_next = CKS_HELD;
      default: state_next = CKS_WAIT_CFG;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= CKS_WAIT_CFG;
      cfg_reg <= '0;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
    end
  end

  // ==========================================================
  // Locked source encoder and key store
  logic [3:0] locked_src;
  logic [31:0] key_rdata;
  logic key_wr;

  cks_src_enc cks_src_enc_inst (
    .clk(clk),
    .rstn(rstn),
    .field(cfg_reg.locked_key_source),
    .source(locked_src)
  );

  function automatic logic is_key_addr(input logic [3:0] a);
    return a[3:2] == 2'(`CKS_OFF_KEY0 >> 2);
  endfunction

  assign key_wr = reg_wr && is_key_addr(reg_addr);

  cks_key_mem #(.WIDTH(32), .DEPTH(4)) cks_key_mem_inst (
    .clk(clk),
    .rstn(rstn),
    .wr_en(key_wr),
    .wr_addr(reg_addr[1:0]),
    .wr_data(reg_wdata),
    .rd_addr(reg_addr[1:0]),
    .rd_data(key_rdata)
  );

  // ==========================================================
  // Control, selection and operation start
  logic [31:0] ctrl_reg, ctrl_next;
  logic [3:0] src_next;
  logic fail_next, start_next, grant_next, refuse_next;
  logic [127:0] skey_reg, skey_next;
  logic held;
  logic rd_pend_reg, key_rd_reg;
  logic [31:0] rd_hold_next;
  logic [31:0] rdata_next;

  assign held = state_reg == CKS_HELD;

  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next[`CKS_CTRL_START] = 1'b0;
    if (reg_wr && reg_addr == `CKS_OFF_CTRL) begin
      ctrl_next = reg_wdata;
    end
    if (reg_wr && is_key_addr(reg_addr)) begin
      skey_next = skey_reg;
      skey_next[reg_addr[1:0]*32 +: 32] = reg_wdata;
    end else begin
      skey_next = skey_reg;
    end
    if (cfg_reg.key_source_lock) begin
      src_next = locked_src;
    end else begin
      src_next = ctrl_reg[`CKS_CTRL_SRC_HI:`CKS_CTRL_SRC_LO];
    end
    fail_next = held && cfg_reg.software_key_disable && src_next == `CKS_SRC_SOFTWARE;
    start_next = 1'b0;
    if (ctrl_reg[`CKS_CTRL_START] && held && !fail_next) begin
      // Stored key one only wraps keys when restricted
      if (!(cfg_reg.session_key_only && src_next == 4'h1 &&
            ctrl_reg[`CKS_CTRL_OP_HI:`CKS_CTRL_OP_LO] != 2'(cks_pkg::CKS_OP_KEY_WRAP))) begin
        start_next = 1'b1;
      end
    end
    grant_next = 1'b0;
    refuse_next = 1'b0;
    if (prog_req) begin
      if (held && 32'(prog_page) < PAGES && !cfg_reg.page_write_lock[prog_page]) begin
        grant_next = 1'b1;
      end else begin
        refuse_next = 1'b1;
      end
    end
    rd_hold_next = 32'h0;
    case (reg_addr)
      `CKS_OFF_CTRL: rd_hold_next = ctrl_reg;
      `CKS_OFF_STATUS: rd_hold_next = {26'h0, held, fail_next, src_next};
      `CKS_OFF_CFG: rd_hold_next = {10'h0, cfg_reg};
      default: rd_hold_next = 32'h0;
    endcase
    // Key words come from the shadow copy so read data leave a flip-flop
    rdata_next = 32'h0;
    if (reg_rd) begin
      if (is_key_addr(reg_addr)) begin
        rdata_next = skey_reg[reg_addr[1:0]*32 +: 32];
      end else begin
        rdata_next = rd_hold_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= `CKS_CTRL_RESET;
      skey_reg <= '0;
      active_source <= 4'h0;
      key_failure_flag <= 1'b0;
      use_software_key <= 1'b0;
      op_start <= 1'b0;
      op_kind <= 2'h0;
      stored_alg <= 2'h0;
      software_key <= '0;
      prog_grant <= 1'b0;
      prog_refused <= 1'b0;
      rd_pend_reg <= 1'b0;
      key_rd_reg <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      skey_reg <= skey_next;
      active_source <= src_next;
      key_failure_flag <= fail_next;
      use_software_key <= held && !cfg_reg.software_key_disable && src_next == `CKS_SRC_SOFTWARE;
      op_start <= start_next;
      op_kind <= ctrl_reg[`CKS_CTRL_OP_HI:`CKS_CTRL_OP_LO];
      stored_alg <= cfg_reg.key_type;
      software_key <= skey_reg;
      prog_grant <= grant_next;
      prog_refused <= refuse_next;
      rd_pend_reg <= reg_rd;
      key_rd_reg <= reg_rd && is_key_addr(reg_addr);
      reg_rdata <= rdata_next;
    end
  end

  // ==========================================================
  // Checks
  lock_select_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_reg.key_source_lock && $stable(locked_src) |=> active_source == $past(locked_src))
    else $error("locked source not used");
  sw_select_a: assert property (@(posedge clk) disable iff (!rstn)
    !cfg_reg.key_source_lock && $stable(ctrl_reg) |=> active_source == $past(ctrl_reg[3:0]))
    else $error("software source not used");
  fail_block_a: assert property (@(posedge clk) disable iff (!rstn)
    key_failure_flag |-> !op_start)
    else $error("start while key failed");
  fail_set_a: assert property (@(posedge clk) disable iff (!rstn)
    held && cfg_reg.software_key_disable && src_next == 4'h0 |=> key_failure_flag)
    else $error("failure flag missing");
  swkey_use_a: assert property (@(posedge clk) disable iff (!rstn)
    held && !cfg_reg.software_key_disable && src_next == 4'h0 |=> use_software_key)
    else $error("software key not active");
  page_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    prog_req && prog_page < 4'd9 && cfg_reg.page_write_lock[prog_page] |=> prog_refused && !prog_grant)
    else $error("locked page programmed");
  cfg_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    held |=> $stable(cfg_reg))
    else $error("config changed after load");
  kek_only_a: assert property (@(posedge clk) disable iff (!rstn)
    op_start && cfg_reg.session_key_only && active_source == 4'h1 |-> op_kind == 2'h3)
    else $error("key one misused");
  alg_type_a: assert property (@(posedge clk) disable iff (!rstn)
    held ##1 held |-> stored_alg == cfg_reg.key_type)
    else $error("key type wrong");
  enc_top_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg_reg.locked_key_source[7] ##1 cfg_reg.locked_key_source[7] |-> locked_src == 4'hf)
    else $error("encoder top bit wrong");

  // One check per lower field bit being the highest one set
  for (genvar g = 0; g < 7; g++) begin : gen_enc_chk
    enc_bit_a: assert property (@(posedge clk) disable iff (!rstn)
      (cfg_reg.locked_key_source >> g) == 8'h01 ##1 (cfg_reg.locked_key_source >> g) == 8'h01
      |-> locked_src == 4'(g + 1))
      else $error("encoder bit wrong");
  end

  key_read_a: assert property (@(posedge clk) disable iff (!rstn)
    key_rd_reg |-> reg_rdata == key_rdata)
    else $error("key word read wrong");
  cfg_read_a: assert property (@(posedge clk) disable iff (!rstn)
    rd_pend_reg && $past(reg_addr) == `CKS_OFF_CFG |-> reg_rdata == {10'h0, $past(cfg_reg)})
    else $error("config read wrong");
  no_load_a: assert property (@(posedge clk) disable iff (!rstn)
    !held |=> !op_start)
    else $error("start before config");
  page_free_a: assert property (@(posedge clk) disable iff (!rstn)
    prog_req && held && prog_page < 4'd9 && !cfg_reg.page_write_lock[prog_page] |=> prog_grant)
    else $error("free page refused");

  load_c: cover property (@(posedge clk) disable iff (!rstn) $rose(held));
  fail_c: cover property (@(posedge clk) disable iff (!rstn) $rose(key_failure_flag));
  grant_c: cover property (@(posedge clk) disable iff (!rstn) prog_grant);
  start_c: cover property (@(posedge clk) disable iff (!rstn) op_start && use_software_key);
  wrap_c: cover property (@(posedge clk) disable iff (!rstn) op_start && op_kind == 2'h3);

endmodule : cks_key_source

`default_nettype wire

// ---- hdl/cks_pkg.sv ----
// Purpose: Types of the key-source block
// Assumes: Nothing
// Notes: Constants live in cks_regs.svh
package cks_pkg;

  typedef enum logic [1:0] {
    CKS_ALG_DES,
    CKS_ALG_3DES,
    CKS_ALG_AES128,
    CKS_ALG_AES256
  } cks_alg_t;

  typedef enum logic [1:0] {
    CKS_OP_ENCRYPT,
    CKS_OP_DECRYPT,
    CKS_OP_SESSION,
    CKS_OP_KEY_WRAP
  } cks_op_t;

  typedef struct packed {
    logic [1:0] key_type;
    logic session_key_only;
    logic [7:0] locked_key_source;
    logic key_source_lock;
    logic [8:0] page_write_lock;
    logic software_key_disable;
  } cks_cfg_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cks_bus_t;

endpackage : cks_pkg

// ---- hdl/cks_regs.svh ----
// Purpose: Offsets, field positions and reset values of the key-source block
// Assumes: Word-indexed plain register port
// Notes: Included by the key memory, the key-source block and the bench
`ifndef CKS_REGS_SVH
`define CKS_REGS_SVH

// ==========================================================
// Register offsets (word index)
`define CKS_OFF_CTRL 4'h0
`define CKS_OFF_STATUS 4'h1
`define CKS_OFF_CFG 4'h2
`define CKS_OFF_KEY0 4'h4
`define CKS_OFF_KEY1 4'h5
`define CKS_OFF_KEY2 4'h6
`define CKS_OFF_KEY3 4'h7

// ==========================================================
// Configuration page fields
`define CKS_CFG_KTYPE_HI 21
`define CKS_CFG_KTYPE_LO 20
`define CKS_CFG_SKEY 19
`define CKS_CFG_LSRC_HI 18
`define CKS_CFG_LSRC_LO 11
`define CKS_CFG_LOCK 10
`define CKS_CFG_WRL_HI 9
`define CKS_CFG_WRL_LO 1
`define CKS_CFG_SWDIS 0

// ==========================================================
// Control register fields
`define CKS_CTRL_SRC_HI 3
`define CKS_CTRL_SRC_LO 0
`define CKS_CTRL_OP_HI 5
`define CKS_CTRL_OP_LO 4
`define CKS_CTRL_START 8
`define CKS_CTRL_KEK 9

// ==========================================================
// Reset values and the software key source code
`define CKS_CTRL_RESET 32'h0000_0000
`define CKS_KEY_RESET 32'h0000_0000
`define CKS_SRC_SOFTWARE 4'h0

`endif

// ---- hdl/cks_src_enc.sv ----
// Purpose: Priority encoder of the locked key source field
// Assumes: Eight-bit field
// Notes: Registered output
`timescale 1ns/100ps
`default_nettype none

module cks_src_enc (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Field in, source out
  input wire logic [7:0] field,
  output logic [3:0] source
);

  logic [3:0] source_next;

  always_comb begin
    source_next = 4'h0;
    for (int i = 0; i < 7; i++) begin
      if (field[i]) begin
        source_next = 4'(i + 1);
      end
    end
    if (field[7]) begin
      source_next = 4'hf;
    end
  end

  always_ff @(posedge clk) begin
    source <= rstn ? source_next : 4'h0;
  end

endmodule : cks_src_enc

`default_nettype wire

// ---- verif/crypto_key_source_config_test.sv ----
// Purpose: Self-checking bench of the key-source block
// Assumes: Page 0 image offered after each reset, once more in the config test to check it is held
// Notes: Level outputs judged after a few settle cycles
`timescale 1ns/100ps
`default_nettype none
`include "cks_regs.svh"

module crypto_key_source_config_test;
  logic clk, rstn, reg_wr, reg_rd, cfg_page_valid, prog_req;
  logic [3:0] reg_addr, prog_page;
  logic [31:0] reg_wdata, reg_rdata, cfg_page_word, rd;
  logic prog_grant, prog_refused, op_start, use_software_key, key_failure_flag;
  logic [1:0] op_kind, stored_alg;
  logic [3:0] active_source;
  logic [127:0] software_key;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  cks_key_source cks_key_source_inst (
    .clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_page_valid(cfg_page_valid), .cfg_page_word(cfg_page_word),
    .prog_req(prog_req), .prog_page(prog_page), .prog_grant(prog_grant), .prog_refused(prog_refused),
    .op_start(op_start), .op_kind(op_kind), .active_source(active_source),
    .use_software_key(use_software_key), .stored_alg(stored_alg), .software_key(software_key),
    .key_failure_flag(key_failure_flag)
  );

  // ==========================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdt(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdt

  task automatic rst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
  endtask : rst

  task automatic load(input logic [31:0] w);
    @(posedge clk);
    cfg_page_valid <= 1'b1;
    cfg_page_word <= w;
    @(posedge clk);
    cfg_page_valid <= 1'b0;
    tick(3);
  endtask : load

  function automatic logic [31:0] cfg(logic [1:0] kt, logic sk, logic [7:0] ls, logic lk, logic [8:0] wl, logic sd);
    return {10'h000, kt, sk, ls, lk, wl, sd};
  endfunction : cfg

  task automatic prog(input logic [3:0] p, input logic ok);
    logic g, r;
    @(posedge clk);
    prog_req <= 1'b1;
    prog_page <= p;
    @(posedge clk);
    prog_req <= 1'b0;
    #1 g = prog_grant;
    r = prog_refused;
    @(posedge clk);
    #1 g = g | prog_grant;
    r = r | prog_refused;
    chk("prog_grant", ok, g);
    chk("prog_refused", !ok, r);
  endtask : prog

  // Selects source first so the failure level settles, then starts
  task automatic start(input logic [3:0] src, input logic [1:0] op, input logic ok);
    int n;
    logic [1:0] k;
    n = 0;
    k = 2'h0;
    wr(`CKS_OFF_CTRL, {26'h0, op, src});
    tick(3);
    wr(`CKS_OFF_CTRL, {23'h0, 1'b1, 2'h0, op, src});
    repeat (5) begin
      @(posedge clk);
      #1 if (op_start === 1'b1) begin
        n++;
        k = op_kind;
      end
    end
    chk("op_start count", ok, n);
    if (ok) chk("op_kind", op, k);
  endtask : start

  // ==========================================================
  // Scenarios
  task automatic test_config();
    logic [31:0] w;
    w = cfg(2'h2, 1'b1, 8'hff, 1'b0, 9'h005, 1'b1);
    rst();
    prog(4'h3, 1'b0);
    rdt(`CKS_OFF_CTRL);
    chk("ctrl reset", 32'h0, rd);
    rdt(4'h3);
    chk("unmapped read", 32'h0, rd);
    load(w);
    rdt(`CKS_OFF_CFG);
    chk("cfg image", {10'h0, w[21:0]}, rd);
    load(cfg(2'h1, 1'b0, 8'h00, 1'b1, 9'h1ff, 1'b0));
    rdt(`CKS_OFF_CFG);
    chk("cfg held", {10'h0, w[21:0]}, rd);
    chk("stored_alg", 2'h2, stored_alg);
    for (int p = 0; p < 10; p++) begin
      prog(p[3:0], p < 9 && !w[p + 1]);
    end
    start(4'h0, 2'h0, 1'b0);
    chk("key_failure_flag", 1'b1, key_failure_flag);
    rdt(`CKS_OFF_STATUS);
    chk("status failure", 6'h30, rd[5:0]);
    start(4'h3, 2'h1, 1'b1);
    chk("key_failure_flag", 1'b0, key_failure_flag);
    chk("active_source", 4'h3, active_source);
    start(4'h1, 2'h0, 1'b0);
    start(4'h1, 2'h3, 1'b1);
    $display("test_config done");
  endtask : test_config

  task automatic test_lock();
    logic [7:0] f;
    logic [3:0] e;
    for (int i = 0; i < 9; i++) begin
      f = (i == 0) ? 8'h00 : 8'((9'h001 << i) - 9'h001);
      e = (i == 8) ? 4'hf : i[3:0];
      rst();
      load(cfg(i[1:0], 1'b0, f, 1'b1, 9'h000, 1'b0));
      wr(`CKS_OFF_CTRL, 32'h0000_000a);
      tick(4);
      chk("locked source", e, active_source);
      rdt(`CKS_OFF_STATUS);
      chk("status source", e, rd[3:0]);
      chk("stored_alg", i[1:0], stored_alg);
    end
    $display("test_lock done");
  endtask : test_lock

  task automatic test_softkey();
    rst();
    load(cfg(2'h3, 1'b0, 8'hff, 1'b0, 9'h000, 1'b0));
    for (int j = 0; j < 4; j++) begin
      wr(4'(`CKS_OFF_KEY0 + j), 32'h1111_1111 * (j + 1));
    end
    wr(`CKS_OFF_CTRL, 32'h0);
    tick(3);
    chk("active_source", 4'h0, active_source);
    chk("use_software_key", 1'b1, use_software_key);
    chk("key_failure_flag", 1'b0, key_failure_flag);
    chk("software_key", 128'h4444_4444_3333_3333_2222_2222_1111_1111, software_key);
    rdt(`CKS_OFF_KEY2);
    chk("key word 2", 32'h3333_3333, rd);
    start(4'h0, 2'h2, 1'b1);
    wr(`CKS_OFF_CTRL, 32'h2);
    tick(3);
    chk("use_software_key", 1'b0, use_software_key);
    $display("test_softkey done");
  endtask : test_softkey

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    cfg_page_valid = 1'b0;
    cfg_page_word = 32'h0;
    prog_req = 1'b0;
    prog_page = 4'h0;
    test_config();
    test_lock();
    test_softkey();
    finish_test();
  end
endmodule : crypto_key_source_config_test

`default_nettype wire
